// >>> dtta_top.sv
// four independent capture/compare timers with dma triggers and an axi4-lite register slave
//
// Summary of operation
// - four independent 32-bit timers, own registers each
// - count source: system clock or external pin
// - system clock predivided by 16 or 1
// - 8-bit prescaler alone advances the counter
// - capture or reference compare mode per timer
// - event drives output, interrupt and/or dma
// - timer n event triggers dma channel n
//
// Local design decisions: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none

module dtta_top (
    input wire logic clk,
    input wire logic sys_rst,
    input wire dtta_pkg::dtta_axi_req_t axi_req,
    output var dtta_pkg::dtta_axi_rsp_t axi_rsp,
    input wire logic [3:0] external_timer_clock_input,
    input wire logic [3:0] capture_input,
    output logic [3:0] timer_output,
    output logic [3:0] dma_trigger,
    output logic irq
);
    import dtta_pkg::*;

    dtta_state_t q;
    dtta_state_t next_q;

    logic wr_fire;
    logic wr_hit;
    logic [1:0] wr_tmr;
    logic [4:0] wr_ofs;
    logic [31:0] wr_bits;
    logic aw_take;
    logic w_take;
    logic ar_take;
    logic [3:0] evt_cap;
    logic [3:0] evt_ref;
    logic [3:0] cnt_wr;
    logic [3:0] src_tick;
    logic [1:0] stat_clr [DTTA_TIMERS];

    function automatic logic addr_ok(input logic [7:0] a);
        return (a[7] == 1'b0) && ({a[4:2], 2'b00} <= DTTA_OFS_MASK);
    endfunction

    function automatic logic [31:0] strb_mask(input logic [3:0] s);
        return {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    endfunction

    // three-stage sampling: a level change counts only once stages two and three agree
    function automatic logic filt(input logic [2:0] sh, input logic lvl);
        return (sh[1] == sh[2]) ? sh[2] : lvl;
    endfunction

    function automatic logic [31:0] rd_word(input dtta_tmr_t t, input logic [4:0] ofs);
        case (ofs)
            DTTA_OFS_CFG: return t.cfg;
            DTTA_OFS_REF: return t.ref_val;
            DTTA_OFS_CAP: return t.cap;
            DTTA_OFS_CNT: return t.cnt;
            DTTA_OFS_STAT: return {30'h0, t.stat};
            DTTA_OFS_MASK: return {30'h0, t.mask};
            default: return 32'h0;
        endcase
    endfunction

    // bus handshakes: one write and one read in flight, answered from registers
    assign axi_rsp.awready = ~q.axi.aw_got & ~q.axi.bvalid;
    assign axi_rsp.wready = ~q.axi.w_got & ~q.axi.bvalid;
    assign axi_rsp.bvalid = q.axi.bvalid;
    assign axi_rsp.bresp = q.axi.bresp;
    assign axi_rsp.arready = ~q.axi.rvalid;
    assign axi_rsp.rvalid = q.axi.rvalid;
    assign axi_rsp.rdata = q.axi.rdata;
    assign axi_rsp.rresp = q.axi.rresp;

    assign aw_take = axi_req.awvalid & axi_rsp.awready;
    assign w_take = axi_req.wvalid & axi_rsp.wready;
    assign ar_take = axi_req.arvalid & axi_rsp.arready;

    // a write is applied in the cycle after both address and data are held
    assign wr_fire = q.axi.aw_got & q.axi.w_got & ~q.axi.bvalid;
    assign wr_hit = wr_fire & addr_ok(q.axi.awaddr);
    assign wr_tmr = q.axi.awaddr[6:5];
    assign wr_ofs = {q.axi.awaddr[4:2], 2'b00};
    assign wr_bits = strb_mask(q.axi.wstrb);

    genvar g;
    generate
        for (g = 0; g < DTTA_TIMERS; g++) begin : g_dec
            assign cnt_wr[g] = wr_hit && (wr_tmr == 2'(g)) && (wr_ofs == DTTA_OFS_CNT);
            assign stat_clr[g] = (wr_hit && (wr_tmr == 2'(g)) && (wr_ofs == DTTA_OFS_STAT) && q.axi.wstrb[0])
                ? q.axi.wdata[1:0] : 2'b00;
            assign timer_output[g] = q.tmr[g].out_lvl;
            assign dma_trigger[g] = q.tmr[g].dma_pulse;
        end
    endgenerate

    always_comb begin
        logic en;
        logic cnt_tick;
        logic cap_edge;
        logic [1:0] set;
        logic [31:0] wm;
        en = 1'b0;
        cnt_tick = 1'b0;
        cap_edge = 1'b0;
        set = 2'b00;
        wm = 32'h0;
        next_q = q;
        evt_cap = 4'h0;
        evt_ref = 4'h0;
        src_tick = 4'h0;

        // each timer has its own copy of every register and counter
        for (int i = 0; i < DTTA_TIMERS; i++) begin
            en = q.tmr[i].cfg[DTTA_CFG_EN];
            cnt_tick = 1'b0;
            set = 2'b00;

            next_q.tmr[i].ext_sh = {q.tmr[i].ext_sh[1:0], external_timer_clock_input[i]};
            next_q.tmr[i].ext_lvl = filt(q.tmr[i].ext_sh, q.tmr[i].ext_lvl);
            next_q.tmr[i].cin_sh = {q.tmr[i].cin_sh[1:0], capture_input[i]};
            next_q.tmr[i].cin_lvl = filt(q.tmr[i].cin_sh, q.tmr[i].cin_lvl);

            if (!en) begin
                next_q.tmr[i].div_cnt = 4'h0;
                next_q.tmr[i].pre_cnt = 8'h0;
                next_q.tmr[i].cnt = 32'h0;
            end else begin
                if (q.tmr[i].cfg[DTTA_CFG_CLKSEL]) begin
                    src_tick[i] = next_q.tmr[i].ext_lvl & ~q.tmr[i].ext_lvl;
                end else if (q.tmr[i].cfg[DTTA_CFG_DIV16]) begin
                    src_tick[i] = (q.tmr[i].div_cnt == DTTA_DIV16_LAST);
                    next_q.tmr[i].div_cnt = q.tmr[i].div_cnt + 4'h1;
                end else begin
                    src_tick[i] = 1'b1;
                end
                // prescale value p divides by p+1
                if (src_tick[i]) begin
                    if (q.tmr[i].pre_cnt == q.tmr[i].cfg[DTTA_CFG_PRE_HI:DTTA_CFG_PRE_LO]) begin
                        next_q.tmr[i].pre_cnt = 8'h0;
                        cnt_tick = 1'b1;
                    end else begin
                        next_q.tmr[i].pre_cnt = q.tmr[i].pre_cnt + 8'h1;
                    end
                end
                if (cnt_tick) begin
                    evt_ref[i] = ~q.tmr[i].cfg[DTTA_CFG_CAPMODE] && (q.tmr[i].cnt == q.tmr[i].ref_val);
                    if (evt_ref[i] && q.tmr[i].cfg[DTTA_CFG_RESTART]) begin
                        next_q.tmr[i].cnt = 32'h0;
                    end else begin
                        next_q.tmr[i].cnt = q.tmr[i].cnt + 32'h1;
                    end
                end
                cap_edge = (q.tmr[i].cfg[DTTA_CFG_RISE] && next_q.tmr[i].cin_lvl && !q.tmr[i].cin_lvl)
                    || (q.tmr[i].cfg[DTTA_CFG_FALL] && !next_q.tmr[i].cin_lvl && q.tmr[i].cin_lvl);
                evt_cap[i] = q.tmr[i].cfg[DTTA_CFG_CAPMODE] && cap_edge;
                if (evt_cap[i]) begin
                    next_q.tmr[i].cap = q.tmr[i].cnt;
                end
            end

            set[DTTA_ST_CAP] = evt_cap[i];
            set[DTTA_ST_REF] = evt_ref[i];
            // an event in the clearing cycle survives the clear
            next_q.tmr[i].stat = (q.tmr[i].stat & ~stat_clr[i]) | set;
            next_q.tmr[i].dma_pulse = (evt_cap[i] | evt_ref[i]) & q.tmr[i].cfg[DTTA_CFG_DMAEN];
            if ((evt_cap[i] | evt_ref[i]) && q.tmr[i].cfg[DTTA_CFG_OUTEN]) begin
                next_q.tmr[i].out_lvl = ~q.tmr[i].out_lvl;
            end

            if (wr_hit && (wr_tmr == 2'(i))) begin
                wm = wr_bits;
                case (wr_ofs)
                    DTTA_OFS_CFG: next_q.tmr[i].cfg = ((q.tmr[i].cfg & ~wm) | (q.axi.wdata & wm)) & DTTA_CFG_WMASK;
                    DTTA_OFS_REF: next_q.tmr[i].ref_val = (q.tmr[i].ref_val & ~wm) | (q.axi.wdata & wm);
                    // any write restarts the count from zero, whatever the data
                    DTTA_OFS_CNT: next_q.tmr[i].cnt = 32'h0;
                    DTTA_OFS_MASK: begin
                        if (q.axi.wstrb[0]) begin
                            next_q.tmr[i].mask = q.axi.wdata[1:0];
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end

        if (aw_take) begin
            next_q.axi.aw_got = 1'b1;
            next_q.axi.awaddr = axi_req.awaddr;
        end
        if (w_take) begin
            next_q.axi.w_got = 1'b1;
            next_q.axi.wdata = axi_req.wdata;
            next_q.axi.wstrb = axi_req.wstrb;
        end
        if (wr_fire) begin
            next_q.axi.aw_got = 1'b0;
            next_q.axi.w_got = 1'b0;
            next_q.axi.bvalid = 1'b1;
            next_q.axi.bresp = wr_hit ? DTTA_RESP_OKAY : DTTA_RESP_SLVERR;
        end else if (q.axi.bvalid && axi_req.bready) begin
            next_q.axi.bvalid = 1'b0;
        end
        if (ar_take) begin
            next_q.axi.rvalid = 1'b1;
            next_q.axi.rdata = addr_ok(axi_req.araddr)
                ? rd_word(q.tmr[axi_req.araddr[6:5]], {axi_req.araddr[4:2], 2'b00}) : 32'h0;
            next_q.axi.rresp = addr_ok(axi_req.araddr) ? DTTA_RESP_OKAY : DTTA_RESP_SLVERR;
        end else if (q.axi.rvalid && axi_req.rready) begin
            next_q.axi.rvalid = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            q <= '0;
            for (int i = 0; i < DTTA_TIMERS; i++) begin
                q.tmr[i].cfg <= DTTA_CFG_RST;
                q.tmr[i].ref_val <= DTTA_REF_RST;
            end
        end else begin
            q <= next_q;
        end
    end

    // one level interrupt for all four timers, gated per event by the mask
    always_comb begin
        irq = 1'b0;
        for (int i = 0; i < DTTA_TIMERS; i++) begin
            irq = irq | (|(q.tmr[i].stat & q.tmr[i].mask));
        end
    end

    generate
        for (g = 0; g < DTTA_TIMERS; g++) begin : g_chk
            cnt_idle_a: assert property (@(posedge clk) disable iff (sys_rst)
                !q.tmr[g].cfg[DTTA_CFG_EN] |=> q.tmr[g].cnt == 32'h0)
                else $error("disabled timer counter not held at zero");

            ext_src_a: assert property (@(posedge clk) disable iff (sys_rst)
                q.tmr[g].cfg[DTTA_CFG_EN] && q.tmr[g].cfg[DTTA_CFG_CLKSEL] && !src_tick[g]
                |=> $stable(q.tmr[g].pre_cnt))
                else $error("prescaler moved without an external clock edge");

            div16_a: assert property (@(posedge clk) disable iff (sys_rst)
                q.tmr[g].cfg[DTTA_CFG_EN] && !q.tmr[g].cfg[DTTA_CFG_CLKSEL] && q.tmr[g].cfg[DTTA_CFG_DIV16]
                && q.tmr[g].div_cnt != DTTA_DIV16_LAST |=> $stable(q.tmr[g].pre_cnt))
                else $error("prescaler moved between divide-by-16 ticks");

            presc_gate_a: assert property (@(posedge clk) disable iff (sys_rst)
                q.tmr[g].cfg[DTTA_CFG_EN]
                && q.tmr[g].pre_cnt != q.tmr[g].cfg[DTTA_CFG_PRE_HI:DTTA_CFG_PRE_LO] && !cnt_wr[g]
                |=> $stable(q.tmr[g].cnt))
                else $error("counter advanced without prescaler wrap");

            cap_mode_a: assert property (@(posedge clk) disable iff (sys_rst)
                q.tmr[g].cfg[DTTA_CFG_CAPMODE] && !q.tmr[g].stat[DTTA_ST_REF] |=> !q.tmr[g].stat[DTTA_ST_REF])
                else $error("reference flag set in capture mode");

            out_toggle_a: assert property (@(posedge clk) disable iff (sys_rst)
                (evt_cap[g] || evt_ref[g]) && q.tmr[g].cfg[DTTA_CFG_OUTEN]
                |=> timer_output[g] != $past(timer_output[g]))
                else $error("timer output did not toggle on event");

            stat_sticky_a: assert property (@(posedge clk) disable iff (sys_rst)
                q.tmr[g].stat[DTTA_ST_REF] && !stat_clr[g][DTTA_ST_REF] |=> q.tmr[g].stat[DTTA_ST_REF])
                else $error("reference flag lost without a clear");

            dma_fire_a: assert property (@(posedge clk) disable iff (sys_rst)
                (evt_cap[g] || evt_ref[g]) && q.tmr[g].cfg[DTTA_CFG_DMAEN]
                |=> dma_trigger[g] ##1 (!dma_trigger[g] || $past(evt_cap[g] || evt_ref[g])))
                else $error("dma trigger not a single pulse after event");

            dma_cause_a: assert property (@(posedge clk) disable iff (sys_rst)
                dma_trigger[g] |-> $past(evt_cap[g] || evt_ref[g]))
                else $error("dma trigger without a timer event");

            cap_value_a: assert property (@(posedge clk) disable iff (sys_rst)
                evt_cap[g] |=> q.tmr[g].cap == $past(q.tmr[g].cnt) && q.tmr[g].stat[DTTA_ST_CAP])
                else $error("capture register or flag wrong after capture");

            ref_flag_a: assert property (@(posedge clk) disable iff (sys_rst)
                evt_ref[g] |=> q.tmr[g].stat[DTTA_ST_REF])
                else $error("reference flag not set after match");

            cnt_restart_a: assert property (@(posedge clk) disable iff (sys_rst)
                evt_ref[g] && q.tmr[g].cfg[DTTA_CFG_RESTART] |=> q.tmr[g].cnt == 32'h0)
                else $error("counter not restarted after match");

            out_quiet_a: assert property (@(posedge clk) disable iff (sys_rst)
                !(evt_cap[g] || evt_ref[g]) |=> $stable(timer_output[g]))
                else $error("timer output moved without an event");

            dma_quiet_a: assert property (@(posedge clk) disable iff (sys_rst)
                !q.tmr[g].cfg[DTTA_CFG_DMAEN] |=> !dma_trigger[g])
                else $error("dma trigger with dma disabled");

            fast_src_a: assert property (@(posedge clk) disable iff (sys_rst)
                q.tmr[g].cfg[DTTA_CFG_EN] && !q.tmr[g].cfg[DTTA_CFG_CLKSEL] && !q.tmr[g].cfg[DTTA_CFG_DIV16]
                |-> src_tick[g])
                else $error("undivided system clock did not tick");

            cnt_step_a: assert property (@(posedge clk) disable iff (sys_rst)
                q.tmr[g].cfg[DTTA_CFG_EN] && src_tick[g] && !cnt_wr[g] && !evt_ref[g]
                && q.tmr[g].pre_cnt == q.tmr[g].cfg[DTTA_CFG_PRE_HI:DTTA_CFG_PRE_LO]
                |=> q.tmr[g].cnt == $past(q.tmr[g].cnt) + 32'h1)
                else $error("counter did not step on prescaler wrap");

            irq_level_a: assert property (@(posedge clk) disable iff (sys_rst)
                (|(q.tmr[g].stat & q.tmr[g].mask)) |-> irq)
                else $error("unmasked status without interrupt");

            idle_event_a: assert property (@(posedge clk) disable iff (sys_rst)
                !q.tmr[g].cfg[DTTA_CFG_EN] |-> !evt_cap[g] && !evt_ref[g])
                else $error("event raised by a disabled timer");

            cnt_clear_a: assert property (@(posedge clk) disable iff (sys_rst)
                cnt_wr[g] |=> q.tmr[g].cnt == 32'h0)
                else $error("counter not cleared by a write");
        end
    endgenerate

    rd_answer_a: assert property (@(posedge clk) disable iff (sys_rst)
        ar_take |=> axi_rsp.rvalid)
        else $error("read not answered in the next cycle");

    wr_answer_a: assert property (@(posedge clk) disable iff (sys_rst)
        wr_fire |=> axi_rsp.bvalid)
        else $error("write not answered after address and data");

    rd_slverr_a: assert property (@(posedge clk) disable iff (sys_rst)
        ar_take && axi_req.araddr[7] |=> axi_rsp.rresp == DTTA_RESP_SLVERR)
        else $error("unmapped read not refused");

    wr_slverr_a: assert property (@(posedge clk) disable iff (sys_rst)
        wr_fire && q.axi.awaddr[7] |=> axi_rsp.bresp == DTTA_RESP_SLVERR)
        else $error("unmapped write not refused");

endmodule // dtta_top

`default_nettype wire

// >>> dtta_pkg.sv
// constants, register map and carrier types of the four-timer array
package dtta_pkg;

    localparam int DTTA_TIMERS = 4;

    // register map: one 32-byte window per timer, byte offsets inside it
    localparam logic [7:0] DTTA_TMR_STRIDE = 8'h20;
    localparam logic [4:0] DTTA_OFS_CFG = 5'h00;
    localparam logic [4:0] DTTA_OFS_REF = 5'h04;
    localparam logic [4:0] DTTA_OFS_CAP = 5'h08;
    localparam logic [4:0] DTTA_OFS_CNT = 5'h0c;
    localparam logic [4:0] DTTA_OFS_STAT = 5'h10;
    localparam logic [4:0] DTTA_OFS_MASK = 5'h14;

    // configuration field positions
    localparam int DTTA_CFG_EN = 0;
    localparam int DTTA_CFG_CLKSEL = 1;
    localparam int DTTA_CFG_DIV16 = 2;
    localparam int DTTA_CFG_CAPMODE = 3;
    localparam int DTTA_CFG_RISE = 4;
    localparam int DTTA_CFG_FALL = 5;
    localparam int DTTA_CFG_RESTART = 6;
    localparam int DTTA_CFG_OUTEN = 7;
    localparam int DTTA_CFG_DMAEN = 8;
    localparam int DTTA_CFG_PRE_LO = 16;
    localparam int DTTA_CFG_PRE_HI = 23;
    localparam logic [31:0] DTTA_CFG_WMASK = 32'h00ff01ff;

    // status and mask field positions
    localparam int DTTA_ST_CAP = 0;
    localparam int DTTA_ST_REF = 1;

    // values after reset
    localparam logic [31:0] DTTA_CFG_RST = 32'h00000000;
    localparam logic [31:0] DTTA_REF_RST = 32'hffffffff;

    // last count of the divide-by-16 stage
    localparam logic [3:0] DTTA_DIV16_LAST = 4'hf;

    localparam logic [1:0] DTTA_RESP_OKAY = 2'h0;
    localparam logic [1:0] DTTA_RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic awvalid;
        logic [7:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [7:0] araddr;
        logic rready;
    } dtta_axi_req_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } dtta_axi_rsp_t;

    typedef struct packed {
        logic [31:0] cfg;
        logic [31:0] ref_val;
        logic [31:0] cap;
        logic [31:0] cnt;
        logic [1:0] stat;
        logic [1:0] mask;
        logic [3:0] div_cnt;
        logic [7:0] pre_cnt;
        logic [2:0] ext_sh;
        logic ext_lvl;
        logic [2:0] cin_sh;
        logic cin_lvl;
        logic out_lvl;
        logic dma_pulse;
    } dtta_tmr_t;

    typedef struct packed {
        logic aw_got;
        logic [7:0] awaddr;
        logic w_got;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } dtta_axi_t;

    typedef struct packed {
        dtta_tmr_t [DTTA_TIMERS-1:0] tmr;
        dtta_axi_t axi;
    } dtta_state_t;

endpackage

// >>> dtta_far_model.sv
// far side of the timer array: dma channels that start on triggers and external count clocks
`timescale 1ns/1ps
`default_nettype none

module dtta_far_model (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [3:0] dma_trigger,
    input wire logic [3:0] ext_run,
    output logic [3:0] external_timer_clock_input,
    output logic [3:0][7:0] dma_starts,
    output logic [3:0][15:0] dma_gap
);
    logic [3:0][15:0] since;
    logic [1:0] phase;

    // sampled mid-cycle so a one-cycle trigger pulse is never missed or seen twice
    always @(negedge clk) begin
        for (int i = 0; i < 4; i++) begin
            if (sys_rst) begin
                dma_starts[i] <= 8'h00;
                since[i] <= 16'h0000;
                dma_gap[i] <= 16'h0000;
            end else if (dma_trigger[i]) begin
                dma_starts[i] <= dma_starts[i] + 8'h01;
                dma_gap[i] <= since[i] + 16'h0001;
                since[i] <= 16'h0000;
            end else begin
                since[i] <= since[i] + 16'h0001;
            end
        end
    end

    // eight-cycle external clock; a stopped pin stands still low
    always @(posedge clk) begin
        if (sys_rst) begin
            phase <= 2'h0;
            external_timer_clock_input <= 4'h0;
        end else begin
            phase <= phase + 2'h1;
            for (int i = 0; i < 4; i++) begin
                if (!ext_run[i]) begin
                    external_timer_clock_input[i] <= 1'b0;
                end else if (phase == 2'h3) begin
                    external_timer_clock_input[i] <= ~external_timer_clock_input[i];
                end
            end
        end
    end
endmodule // dtta_far_model

`default_nettype wire

// >>> tb_top.sv
// self-checking bench for the four-timer array
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    import dtta_pkg::*;

    typedef struct packed {
        logic wr;
        logic [31:0] d;
        logic [1:0] r;
    } dtta_exp_t;

    logic clk;
    logic sys_rst;
    dtta_axi_req_t axi_req;
    dtta_axi_rsp_t axi_rsp;
    logic [3:0] ext_pin;
    logic [3:0] ext_run;
    logic [3:0] capture_input;
    logic [3:0] timer_output;
    logic [3:0] dma_trigger;
    logic irq;
    logic [3:0][7:0] far_starts;
    logic [3:0][15:0] far_gap;
    dtta_exp_t exp_q[$];
    dtta_exp_t e;
    int n_errors;
    int cmp_count;
    logic [7:0] rnd;
    logic [31:0] rref;

    dtta_top i_dut (
        .clk(clk),
        .sys_rst(sys_rst),
        .axi_req(axi_req),
        .axi_rsp(axi_rsp),
        .external_timer_clock_input(ext_pin),
        .capture_input(capture_input),
        .timer_output(timer_output),
        .dma_trigger(dma_trigger),
        .irq(irq)
    );

    dtta_far_model i_far (
        .clk(clk),
        .sys_rst(sys_rst),
        .dma_trigger(dma_trigger),
        .ext_run(ext_run),
        .external_timer_clock_input(ext_pin),
        .dma_starts(far_starts),
        .dma_gap(far_gap)
    );

    always #5 clk = ~clk;

    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction

    function automatic logic [7:0] adr(input logic [1:0] n, input logic [4:0] o);
        return {1'b0, n, o};
    endfunction

    function automatic logic [31:0] cfgw(input logic [8:0] b, input logic [7:0] p);
        return {8'h00, p, 7'h00, b};
    endfunction

    task automatic conclude();
        $display("checks %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic chk_bus(input string name, input logic [33:0] ex, input logic [33:0] got);
        cmp_count++;
        if (got !== ex) begin
            n_errors++;
            $display("FAIL %s expected %h seen %h", name, ex, got);
        end
    endtask

    task automatic chk_pin(input string name, input logic [31:0] ex, input logic [31:0] got);
        cmp_count++;
        if (got !== ex) begin
            n_errors++;
            $display("FAIL %s expected %h seen %h", name, ex, got);
        end
    endtask

    // one register access; for a write d is the data, for a read the expected data
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        logic done;
        logic ta;
        logic tw;
        logic tr;
        exp_q.push_back('{wr, d, r});
        @(posedge clk);
        if (wr) begin
            axi_req.awvalid <= 1'b1;
            axi_req.awaddr <= a;
            axi_req.wvalid <= 1'b1;
            axi_req.wdata <= d;
            axi_req.wstrb <= 4'hf;
            axi_req.bready <= 1'b1;
        end else begin
            axi_req.arvalid <= 1'b1;
            axi_req.araddr <= a;
            axi_req.rready <= 1'b1;
        end
        done = 1'b0;
        while (!done) begin
            @(negedge clk);
            ta = axi_req.awvalid && axi_rsp.awready || axi_req.arvalid && axi_rsp.arready;
            tw = axi_req.wvalid && axi_rsp.wready;
            tr = axi_rsp.bvalid && axi_req.bready || axi_rsp.rvalid && axi_req.rready;
            @(posedge clk);
            if (ta) begin
                axi_req.awvalid <= 1'b0;
                axi_req.arvalid <= 1'b0;
            end
            if (tw) begin
                axi_req.wvalid <= 1'b0;
            end
            if (tr) begin
                axi_req.bready <= 1'b0;
                axi_req.rready <= 1'b0;
                done = 1'b1;
            end
        end
    endtask

    task automatic waitc(input int k);
        repeat (k) @(posedge clk);
        @(negedge clk);
    endtask

    // bus answers are matched against the oldest note, half a cycle before the taking edge
    always @(negedge clk) begin
        if (axi_rsp.rvalid && axi_req.rready || axi_rsp.bvalid && axi_req.bready) begin
            if (exp_q.size() == 0) begin
                chk_bus("unexpected answer", 34'h0, 34'h1);
            end else begin
                e = exp_q.pop_front();
                if (e.wr) begin
                    chk_bus("bresp", {e.r, 32'h0}, {axi_rsp.bresp, 32'h0});
                end else begin
                    chk_bus("rdata", {e.r, e.d}, {axi_rsp.rresp, axi_rsp.rdata});
                end
            end
        end
    end

    initial begin
        #100000;
        n_errors++;
        conclude();
    end

    initial begin
        clk = 1'b0;
        sys_rst = 1'b1;
        axi_req = '0;
        ext_run = 4'h0;
        capture_input = 4'h0;
        n_errors = 0;
        cmp_count = 0;
        rnd = 8'h62;
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        bus(1'b0, adr(0, DTTA_OFS_CFG), DTTA_CFG_RST, DTTA_RESP_OKAY);
        bus(1'b0, adr(3, DTTA_OFS_REF), DTTA_REF_RST, DTTA_RESP_OKAY);
        bus(1'b0, 8'h80, 32'h0, DTTA_RESP_SLVERR);
        bus(1'b0, 8'h18, 32'h0, DTTA_RESP_SLVERR);
        bus(1'b1, 8'h80, 32'h1234, DTTA_RESP_SLVERR);
        rnd = lfsr(rnd);
        rref = {rnd, ~rnd, rnd ^ 8'h5a, rnd};
        bus(1'b1, adr(1, DTTA_OFS_REF), rref, DTTA_RESP_OKAY);
        bus(1'b0, adr(1, DTTA_OFS_REF), rref, DTTA_RESP_OKAY);
        bus(1'b0, adr(2, DTTA_OFS_REF), DTTA_REF_RST, DTTA_RESP_OKAY);
        // compare mode on timer 0: one match, no restart
        bus(1'b1, adr(0, DTTA_OFS_MASK), 32'h2, DTTA_RESP_OKAY);
        bus(1'b1, adr(0, DTTA_OFS_REF), 32'h5, DTTA_RESP_OKAY);
        bus(1'b1, adr(0, DTTA_OFS_CFG), cfgw(9'h181, 8'h00), DTTA_RESP_OKAY);
        waitc(30);
        chk_pin("irq", 32'h1, {31'h0, irq});
        chk_pin("timer_output", 32'h1, {28'h0, timer_output});
        chk_pin("dma starts", 32'h00000001, far_starts);
        bus(1'b0, adr(0, DTTA_OFS_STAT), 32'h2, DTTA_RESP_OKAY);
        bus(1'b1, adr(0, DTTA_OFS_STAT), 32'h2, DTTA_RESP_OKAY);
        waitc(2);
        chk_pin("irq cleared", 32'h0, {31'h0, irq});
        // timer 1: system clock over 16 and a random prescale, restarting at 3
        rnd = lfsr(rnd);
        bus(1'b1, adr(1, DTTA_OFS_REF), 32'h3, DTTA_RESP_OKAY);
        bus(1'b1, adr(1, DTTA_OFS_CFG), cfgw(9'h145, {6'h00, rnd[1:0]}), DTTA_RESP_OKAY);
        waitc(3 * 256 + 40);
        chk_pin("gap timer1", 32'(64 * (rnd[1:0] + 1)), {16'h0, far_gap[1]});
        // timer 2: external clock, prescale 2 (divide by 3), restarting at 1
        @(posedge clk);
        ext_run <= 4'h4;
        bus(1'b1, adr(2, DTTA_OFS_REF), 32'h1, DTTA_RESP_OKAY);
        bus(1'b1, adr(2, DTTA_OFS_CFG), cfgw(9'h143, 8'h02), DTTA_RESP_OKAY);
        waitc(200);
        chk_pin("gap timer2", 32'd48, {16'h0, far_gap[2]});
        @(posedge clk);
        ext_run <= 4'h0;
        // timer 3: capture on rising edge only, counter ticking every 256 cycles
        bus(1'b1, adr(3, DTTA_OFS_MASK), 32'h1, DTTA_RESP_OKAY);
        bus(1'b1, adr(3, DTTA_OFS_CFG), cfgw(9'h119, 8'hff), DTTA_RESP_OKAY);
        waitc(600);
        @(posedge clk);
        capture_input[3] <= 1'b1;
        waitc(10);
        chk_pin("irq capture", 32'h1, {31'h0, irq});
        chk_pin("dma starts 3", 32'h1, {24'h0, far_starts[3]});
        bus(1'b0, adr(3, DTTA_OFS_CAP), 32'h2, DTTA_RESP_OKAY);
        bus(1'b0, adr(3, DTTA_OFS_STAT), 32'h1, DTTA_RESP_OKAY);
        bus(1'b1, adr(3, DTTA_OFS_STAT), 32'h1, DTTA_RESP_OKAY);
        @(posedge clk);
        capture_input[3] <= 1'b0;
        waitc(10);
        bus(1'b0, adr(3, DTTA_OFS_STAT), 32'h0, DTTA_RESP_OKAY);
        chk_pin("dma starts 3 after fall", 32'h1, {24'h0, far_starts[3]});
        // timer 2 has no external clock now, so its count stays where a write leaves it
        bus(1'b1, adr(2, DTTA_OFS_CNT), 32'h5a5a, DTTA_RESP_OKAY);
        bus(1'b0, adr(2, DTTA_OFS_CNT), 32'h0, DTTA_RESP_OKAY);
        bus(1'b1, adr(2, DTTA_OFS_CFG), 32'hfffffffe, DTTA_RESP_OKAY);
        bus(1'b0, adr(2, DTTA_OFS_CFG), DTTA_CFG_WMASK & 32'hfffffffe, DTTA_RESP_OKAY);
        bus(1'b0, adr(3, DTTA_OFS_MASK), 32'h1, DTTA_RESP_OKAY);
        conclude();
    end
endmodule // tb_top

`default_nettype wire
